/* rtl/fpio_defs.svh */
// offsets, field positions, reset values and pin positions of the parallel port block
`ifndef FPIO_DEFS_SVH
`define FPIO_DEFS_SVH
`define FPIO_NUM_PORTS    5
`define FPIO_NUM_PINS     39
`define FPIO_ADDR_W       8
`define FPIO_KIND_DATA    2'h0
`define FPIO_KIND_DIR     2'h1
`define FPIO_KIND_PUE     2'h2
`define FPIO_OFF_CTRL     8'h50
`define FPIO_CTRL_RELEASE 0
`define FPIO_CTRL_GPO     1
`define FPIO_RST_BYTE     8'h00
`define FPIO_PA_OE_MASK   8'hFE
`define FPIO_PA0          0
`define FPIO_PA_PD_LO     4
`define FPIO_PB0          8
`define FPIO_PB1          9
`define FPIO_PB7          15
`define FPIO_PC_KBI       16
`define FPIO_PC_SPI       20
`define FPIO_PD0          24
`define FPIO_PD1          25
`define FPIO_PD6          30
`define FPIO_PE_BASE      31
`endif

/* rtl/fpio_pkg.sv */
// types shared by the parallel port block
`include "fpio_defs.svh"
package fpio_pkg;
	typedef logic [`FPIO_ADDR_W-1:0]   fpio_addr_type;
	typedef logic [7:0]                fpio_byte_type;
	typedef logic [`FPIO_NUM_PINS-1:0] fpio_pins_type;
	typedef enum {FPIO_RUN, FPIO_HOLD} fpio_pwr_type;
endpackage

/* rtl/fpio_port.sv */
// one port slice: data latch, direction, pull enable and pin drive
`timescale 1ns/1ps
`default_nettype none
module fpio_port #(
	parameter int           W       = 8,
	parameter logic [W-1:0] OE_MASK = '1
) (
	input  wire logic  mclk_in, // system clock
	input  wire logic  nrst_in, // async reset, low
	fpio_port_if.port  bus      // control and pins
);
	logic [W-1:0] latch_q;
	logic [W-1:0] dir_q;
	logic [W-1:0] pue_q;
	logic [W-1:0] oe_d;
	logic [W-1:0] out_d;
	logic [W-1:0] pull_ok;
	logic [W-1:0] rd_sel;

	generate
		if (W < 1 || W > 8)
			$error("fpio_port width must be 1 to 8");
	endgenerate

	// ==========================================================
	// registers
	// stop entry powers the registers down, so they clear like reset
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			latch_q <= '0;
		else if (bus.clr)
			latch_q <= '0;
		else if (bus.wr_latch)
			latch_q <= bus.wr_data[W-1:0];
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			dir_q <= '0;
		else if (bus.clr)
			dir_q <= '0;
		else if (bus.wr_dir)
			dir_q <= bus.wr_data[W-1:0];
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			pue_q <= '0;
		else if (bus.clr)
			pue_q <= '0;
		else if (bus.wr_pue)
			pue_q <= bus.wr_data[W-1:0];
	end

	// ==========================================================
	// pin drive
	always_comb begin
		oe_d    = ((bus.own & bus.own_oe) | (~bus.own & dir_q)) & OE_MASK;
		out_d   = (bus.own & bus.own_out) | (~bus.own & latch_q);
		pull_ok = pue_q & ~dir_q & ~oe_d;
		rd_sel  = dir_q & ~bus.pin_force;
	end

	// hold freezes the pads while the registers behind them are gone
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bus.pin_oe  <= '0;
			bus.pin_out <= '0;
			bus.pin_pu  <= '0;
			bus.pin_pd  <= '0;
		end else if (bus.off) begin
			bus.pin_oe  <= '0;
			bus.pin_out <= '0;
			bus.pin_pu  <= '0;
			bus.pin_pd  <= '0;
		end else if (!bus.hold) begin
			bus.pin_oe  <= oe_d;
			bus.pin_out <= out_d;
			bus.pin_pu  <= (pull_ok & ~bus.pd_sel) | bus.force_pu;
			bus.pin_pd  <= pull_ok & bus.pd_sel;
		end
	end

	assign bus.latch   = latch_q;
	assign bus.dir     = dir_q;
	assign bus.pue     = pue_q;
	assign bus.rd_data = (rd_sel & latch_q) | (~rd_sel & bus.pin_lvl);
endmodule
`default_nettype wire

/* rtl/fpio_port_if.sv */
// control and pin bundle between the port block top and one port slice
`timescale 1ns/1ps
`default_nettype none
interface fpio_port_if #(parameter int W = 8);
	logic [7:0]   wr_data;
	logic         wr_latch;
	logic         wr_dir;
	logic         wr_pue;
	logic         clr;
	logic         off;
	logic         hold;
	logic [W-1:0] own;
	logic [W-1:0] own_oe;
	logic [W-1:0] own_out;
	logic [W-1:0] force_pu;
	logic [W-1:0] pd_sel;
	logic [W-1:0] pin_force;
	logic [W-1:0] pin_lvl;
	logic [W-1:0] latch;
	logic [W-1:0] dir;
	logic [W-1:0] pue;
	logic [W-1:0] rd_data;
	logic [W-1:0] pin_out;
	logic [W-1:0] pin_oe;
	logic [W-1:0] pin_pu;
	logic [W-1:0] pin_pd;
	modport port (input wr_data, wr_latch, wr_dir, wr_pue, clr, off, hold, own, own_oe, own_out,
		force_pu, pd_sel, pin_force, pin_lvl,
		output latch, dir, pue, rd_data, pin_out, pin_oe, pin_pu, pin_pd);
	modport ctl (output wr_data, wr_latch, wr_dir, wr_pue, clr, off, hold, own, own_oe, own_out,
		force_pu, pd_sel, pin_force, pin_lvl,
		input latch, dir, pue, rd_data, pin_out, pin_oe, pin_pu, pin_pd);
endinterface
`default_nettype wire

/* rtl/fpio_sync.sv */
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module fpio_sync #(
	parameter int W = 39
) (
	input  wire logic         mclk_in,  // system clock
	input  wire logic         nrst_in,  // async reset, low
	input  wire logic [W-1:0] async_in, // raw pin levels
	output logic      [W-1:0] sync_out  // synchronised levels
);
	logic [W-1:0] meta_q;

	generate
		if (W < 1)
			$error("fpio_sync width must be positive");
	endgenerate

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* rtl/fpio_top.sv */
// five-port parallel i/o block with avalon-mm register slave
//
// Notes on behaviour
// - 39 pins, four 8-bit, one 7-bit port
// - port A bit 0 never drives
// - every port A pin feeds keyboard unit one
// - serial enabled: B0 transmit, B1 receive
// - timer may own port B pin 7
// - SPI enabled: C7..C4 select, clock, MISO, MOSI
// - C3..C0 feed keyboard unit two
// - D0 is background/mode-select line after reset
// - background owner forces D0 pullup on
// - software may turn D0 into output only
// - D1 always belongs to reset function
// - timer may own port D pin 6
// - general drive control only while no owner
// - read gives pin if input, latch if output
// - data write updates the latch unless a stop entry comes in the same cycle
// - drive latch only on unowned output pins and on D0 as plain output
// - direction still selects read source when owned
// - D0 and D1 read the pin level
// - pullup only while direction is input, except the forced D0 pullup
// - stop1 clears registers, pins to reset
// - stop2 holds pins until release write
// - reset clears latches, inputs, no pulls except the forced D0 pullup
// - rising keyboard pins A7..A4 get pulldowns
`timescale 1ns/1ps
`default_nettype none
`include "fpio_defs.svh"
module fpio_top (
	input  wire logic                   mclk_in,             // system clock
	input  wire logic                   nrst_in,             // async reset, low
	input  wire fpio_pkg::fpio_addr_type avs_address_in,     // byte address
	input  wire logic                   avs_read_in,         // read request
	input  wire logic                   avs_write_in,        // write request
	input  wire logic [31:0]            avs_writedata_in,    // write data
	input  wire logic [3:0]             avs_byteenable_in,   // byte lanes
	output logic      [31:0]            avs_readdata_out,    // read data
	output logic                        avs_waitrequest_out, // stall
	input  wire fpio_pkg::fpio_pins_type pin_in,             // pad levels
	output fpio_pkg::fpio_pins_type     pin_out_out,         // pad drive value
	output fpio_pkg::fpio_pins_type     pin_oe_out,          // pad drive enable
	output fpio_pkg::fpio_pins_type     pin_pullup_out,      // pullup enable
	output fpio_pkg::fpio_pins_type     pin_pulldown_out,    // pulldown enable
	output fpio_pkg::fpio_pins_type     pin_level_out,       // synced levels to peripherals
	input  wire logic [7:0]             keyboard_irq_unit_one_en_in,          // keyboard one pin enables
	input  wire logic [7:0]             keyboard_irq_unit_one_rise_in,        // keyboard one rising polarity
	input  wire logic [3:0]             keyboard_irq_unit_two_en_in,          // keyboard two pin enables
	input  wire logic                   sci_en_in,           // serial enabled
	input  wire logic                   serial_transmit_in,  // serial transmit bit
	output logic                        serial_receive_out,  // serial receive level
	input  wire logic                   tmr1_own_in,         // timer owns B7
	input  wire logic                   tmr1_oe_in,          // timer drives B7
	input  wire logic                   tmr1_out_in,         // timer B7 value
	input  wire logic                   tmr0_own_in,         // timer owns D6
	input  wire logic                   tmr0_oe_in,          // timer drives D6
	input  wire logic                   tmr0_out_in,         // timer D6 value
	input  wire logic                   spi_en_in,           // spi enabled
	input  wire logic [3:0]             spi_oe_in,           // spi drive, 3=select..0=mosi
	input  wire logic [3:0]             spi_do_in,           // spi values, same order
	input  wire logic                   bkgd_oe_in,          // background line drives
	input  wire logic                   bkgd_out_in,         // background line value
	input  wire logic                   reset_drive_in,      // pull reset pin low
	input  wire logic                   stop1_entry_in,      // full power down pulse
	input  wire logic                   stop2_entry_in,      // partial power down pulse
	output logic                        hold_active_out      // pins held after stop2
);
	import fpio_pkg::*;

	localparam int NP = `FPIO_NUM_PORTS;

	logic             ack_q;
	logic [31:0]      rdata_q;
	fpio_pwr_type     pwr_q;
	logic             gpo_q;
	logic             wr_fire;
	logic             rd_take;
	logic             ctrl_hit;
	logic             hold_rel;
	logic [3:0]       sel_port;
	logic [1:0]       sel_kind;
	fpio_pins_type    lvl;
	fpio_pins_type    own;
	fpio_pins_type    own_oe;
	fpio_pins_type    own_out;
	fpio_pins_type    force_pu;
	fpio_pins_type    pd_sel;
	fpio_pins_type    pin_force;
	fpio_pins_type    latch_all;
	fpio_pins_type    dir_all;
	fpio_byte_type    rd_arr [NP][3];
	logic             pif_e_wr;

	// ==========================================================
	// pin input synchroniser
	fpio_sync #(.W(`FPIO_NUM_PINS)) u_sync (
		.mclk_in  (mclk_in),
		.nrst_in  (nrst_in),
		.async_in (pin_in),
		.sync_out (lvl)
	);

	assign pin_level_out      = lvl;
	assign serial_receive_out = lvl[`FPIO_PB1];

	// ==========================================================
	// avalon slave
	// one wait cycle on every access so read data come from a flop
	assign sel_port            = avs_address_in[7:4];
	assign sel_kind            = avs_address_in[3:2];
	assign ctrl_hit            = {avs_address_in[7:2], 2'b00} == `FPIO_OFF_CTRL;
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
	assign wr_fire             = avs_write_in & ack_q & avs_byteenable_in[0];
	assign rd_take             = avs_read_in & ~ack_q;
	assign hold_rel            = wr_fire & ctrl_hit & avs_writedata_in[`FPIO_CTRL_RELEASE];
	assign avs_readdata_out    = rdata_q;
	assign pif_e_wr            = wr_fire && sel_port == 4'h4 && sel_kind == `FPIO_KIND_DATA;

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			rdata_q <= '0;
		else if (rd_take) begin
			if (ctrl_hit)
				rdata_q <= {30'h0, gpo_q, pwr_q == FPIO_HOLD};
			else if (sel_port < 4'(NP) && sel_kind != 2'h3)
				rdata_q <= {24'h0, rd_arr[sel_port[2:0]][sel_kind]};
			else
				rdata_q <= '0;
		end
	end

	// ==========================================================
	// power state
	// a stop2 entry in the release cycle wins, so the hold is never lost
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			pwr_q <= FPIO_RUN;
		else begin
			case (pwr_q)
				FPIO_RUN: begin
					if (stop2_entry_in)
						pwr_q <= FPIO_HOLD;
				end
				FPIO_HOLD: begin
					if (hold_rel && !stop2_entry_in)
						pwr_q <= FPIO_RUN;
				end
				default: pwr_q <= FPIO_RUN;
			endcase
		end
	end

	assign hold_active_out = pwr_q == FPIO_HOLD;

	// once set, D0 stays a plain output until reset or power down
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			gpo_q <= 1'b0;
		else if (stop1_entry_in || stop2_entry_in)
			gpo_q <= 1'b0;
		else if (wr_fire && ctrl_hit && avs_writedata_in[`FPIO_CTRL_GPO])
			gpo_q <= 1'b1;
	end

	// ==========================================================
	// peripheral ownership
	always_comb begin
		own       = '0;
		own_oe    = '0;
		own_out   = '0;
		force_pu  = '0;
		pd_sel    = '0;
		pin_force = '0;
		own[`FPIO_PA0 +: 8]      = keyboard_irq_unit_one_en_in;
		pd_sel[`FPIO_PA_PD_LO +: 4] = keyboard_irq_unit_one_en_in[7:4] & keyboard_irq_unit_one_rise_in[7:4];
		if (sci_en_in) begin
			own[`FPIO_PB0]     = 1'b1;
			own_oe[`FPIO_PB0]  = 1'b1;
			own_out[`FPIO_PB0] = serial_transmit_in;
			own[`FPIO_PB1]     = 1'b1;
		end
		if (tmr1_own_in) begin
			own[`FPIO_PB7]     = 1'b1;
			own_oe[`FPIO_PB7]  = tmr1_oe_in;
			own_out[`FPIO_PB7] = tmr1_out_in;
		end
		own[`FPIO_PC_KBI +: 4] = keyboard_irq_unit_two_en_in;
		if (spi_en_in) begin
			own[`FPIO_PC_SPI +: 4]     = 4'hF;
			own_oe[`FPIO_PC_SPI +: 4]  = spi_oe_in;
			own_out[`FPIO_PC_SPI +: 4] = spi_do_in;
		end
		own[`FPIO_PD0]      = 1'b1;
		own_oe[`FPIO_PD0]   = gpo_q | bkgd_oe_in;
		own_out[`FPIO_PD0]  = gpo_q ? latch_all[`FPIO_PD0] : bkgd_out_in;
		force_pu[`FPIO_PD0] = ~gpo_q;
		own[`FPIO_PD1]      = 1'b1;
		own_oe[`FPIO_PD1]   = reset_drive_in;
		pin_force[`FPIO_PD0] = 1'b1;
		pin_force[`FPIO_PD1] = 1'b1;
		if (tmr0_own_in) begin
			own[`FPIO_PD6]     = 1'b1;
			own_oe[`FPIO_PD6]  = tmr0_oe_in;
			own_out[`FPIO_PD6] = tmr0_out_in;
		end
	end

	// ==========================================================
	// port slices: A B C D of 8/8/8/7 pins, then E of 8
	for (genvar i = 0; i < NP; i++) begin : g_port
		localparam int         W   = (i == 3) ? 7 : 8;
		localparam int         B   = (i == 4) ? `FPIO_PE_BASE : i * 8;
		localparam logic [7:0] OEM = (i == 0) ? `FPIO_PA_OE_MASK : 8'hFF;

		fpio_port_if #(.W(W)) pif ();

		assign pif.wr_data   = avs_writedata_in[7:0];
		assign pif.wr_latch  = wr_fire && sel_port == 4'(i) && sel_kind == `FPIO_KIND_DATA;
		assign pif.wr_dir    = wr_fire && sel_port == 4'(i) && sel_kind == `FPIO_KIND_DIR;
		assign pif.wr_pue    = wr_fire && sel_port == 4'(i) && sel_kind == `FPIO_KIND_PUE;
		assign pif.clr       = stop1_entry_in | stop2_entry_in;
		assign pif.off       = stop1_entry_in;
		assign pif.hold      = pwr_q == FPIO_HOLD;
		assign pif.own       = own[B +: W];
		assign pif.own_oe    = own_oe[B +: W];
		assign pif.own_out   = own_out[B +: W];
		assign pif.force_pu  = force_pu[B +: W];
		assign pif.pd_sel    = pd_sel[B +: W];
		assign pif.pin_force = pin_force[B +: W];
		assign pif.pin_lvl   = lvl[B +: W];

		assign latch_all[B +: W]        = pif.latch;
		assign dir_all[B +: W]          = pif.dir;
		assign pin_out_out[B +: W]      = pif.pin_out;
		assign pin_oe_out[B +: W]       = pif.pin_oe;
		assign pin_pullup_out[B +: W]   = pif.pin_pu;
		assign pin_pulldown_out[B +: W] = pif.pin_pd;
		assign rd_arr[i][0]             = 8'(pif.rd_data);
		assign rd_arr[i][1]             = 8'(pif.dir);
		assign rd_arr[i][2]             = 8'(pif.pue);

		fpio_port #(
			.W       (W),
			.OE_MASK (OEM[W-1:0])
		) u_port (
			.mclk_in (mclk_in),
			.nrst_in (nrst_in),
			.bus     (pif.port)
		);
	end

	// ==========================================================
	// assertions
	property p_pa0_input;
		@(posedge mclk_in) disable iff (!nrst_in)
		!pin_oe_out[`FPIO_PA0];
	endproperty
	a_pa0_input: assert property (p_pa0_input) else $error("port A bit 0 driven");

	property p_latch_write;
		@(posedge mclk_in) disable iff (!nrst_in)
		(pif_e_wr && !stop1_entry_in && !stop2_entry_in)
			|=> latch_all[`FPIO_PE_BASE +: 8] == $past(avs_writedata_in[7:0]);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("data write not latched");

	property p_gpio_drive;
		@(posedge mclk_in) disable iff (!nrst_in)
		(pwr_q == FPIO_RUN && !stop1_entry_in)
			|=> pin_oe_out[`FPIO_PE_BASE +: 8] == $past(dir_all[`FPIO_PE_BASE +: 8])
			&& pin_out_out[`FPIO_PE_BASE +: 8] == $past(latch_all[`FPIO_PE_BASE +: 8]);
	endproperty
	a_gpio_drive: assert property (p_gpio_drive) else $error("port E drive mismatch");

	property p_serial_tx;
		@(posedge mclk_in) disable iff (!nrst_in)
		(sci_en_in && pwr_q == FPIO_RUN && !stop1_entry_in)
			|=> pin_oe_out[`FPIO_PB0] && pin_out_out[`FPIO_PB0] == $past(serial_transmit_in);
	endproperty
	a_serial_tx: assert property (p_serial_tx) else $error("serial transmit not on B0");

	property p_bkgd_pullup;
		@(posedge mclk_in) disable iff (!nrst_in)
		// the forced pullup lands one edge after reset release
		($past(nrst_in) && !gpo_q && pwr_q == FPIO_RUN && !stop1_entry_in) |=> pin_pullup_out[`FPIO_PD0];
	endproperty
	a_bkgd_pullup: assert property (p_bkgd_pullup) else $error("D0 pullup off while owned");

	property p_pull_input_only;
		@(posedge mclk_in) disable iff (!nrst_in)
		(pin_pullup_out[`FPIO_PE_BASE +: 8] & pin_oe_out[`FPIO_PE_BASE +: 8]) == 8'h00;
	endproperty
	a_pull_input_only: assert property (p_pull_input_only) else $error("pullup on driven pin");

	property p_stop1_reset;
		@(posedge mclk_in) disable iff (!nrst_in)
		stop1_entry_in |=> pin_oe_out == '0 && pin_pullup_out == '0 && pin_pulldown_out == '0
			&& latch_all == '0 && dir_all == '0;
	endproperty
	a_stop1_reset: assert property (p_stop1_reset) else $error("stop1 left pins active");

	property p_stop2_hold;
		@(posedge mclk_in) disable iff (!nrst_in)
		(pwr_q == FPIO_HOLD && !stop1_entry_in) |=> $stable(pin_out_out) && $stable(pin_oe_out);
	endproperty
	a_stop2_hold: assert property (p_stop2_hold) else $error("held pins changed");

	property p_read_source;
		@(posedge mclk_in) disable iff (!nrst_in)
		(rd_take && sel_port == 4'h4 && sel_kind == `FPIO_KIND_DATA)
			|=> rdata_q[7:0] == (($past(dir_all[`FPIO_PE_BASE +: 8]) & $past(latch_all[`FPIO_PE_BASE +: 8]))
			| (~$past(dir_all[`FPIO_PE_BASE +: 8]) & $past(lvl[`FPIO_PE_BASE +: 8])));
	endproperty
	a_read_source: assert property (p_read_source) else $error("data read source wrong");
endmodule
`default_nettype wire

/* testbench/five_port_parallel_io_bench.sv */
// self-checking bench for the five-port parallel i/o block
`timescale 1ns/1ps
`default_nettype none
module five_port_parallel_io_bench;
	import fpio_pkg::*;
	logic          mclk_in, nrst_in, rd, wr, sci, tx, t1o, t1e, t1v, t0o, spi, rdrv, s1, s2, wq, rx, hold, bk;
	logic [7:0]    adr, k1e, k1r, q;
	logic [3:0]    k2e, spoe, spdo;
	logic [31:0]   wd, rdat;
	fpio_pins_type pin, pout, poe, ppu, ppd, plv, xv, xe;
	int            errors, n_checks;
	fpio_top i_fpio_top (.mclk_in(mclk_in), .nrst_in(nrst_in), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wq), .pin_in(pin), .pin_out_out(pout), .pin_oe_out(poe), .pin_pullup_out(ppu),
		.pin_pulldown_out(ppd), .pin_level_out(plv), .keyboard_irq_unit_one_en_in(k1e), .keyboard_irq_unit_one_rise_in(k1r), .keyboard_irq_unit_two_en_in(k2e),
		.sci_en_in(sci), .serial_transmit_in(tx), .serial_receive_out(rx), .tmr1_own_in(t1o), .tmr1_oe_in(t1e),
		.tmr1_out_in(t1v), .tmr0_own_in(t0o), .tmr0_oe_in(t0o), .tmr0_out_in(t0o), .spi_en_in(spi),
		.spi_oe_in(spoe), .spi_do_in(spdo), .bkgd_oe_in(bk), .bkgd_out_in(bk), .reset_drive_in(rdrv),
		.stop1_entry_in(s1), .stop2_entry_in(s2), .hold_active_out(hold));
	fpio_pad_model i_fpio_pad_model (.mclk_in(mclk_in), .drv_in(pout), .oe_in(poe), .pu_in(ppu), .pd_in(ppd),
		.ext_in(xv), .ext_en_in(xe), .pad_out(pin));
	// =========================================
	// shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk_in);
		adr <= a;
		wd <= {24'h000000, d};
		rd <= !w;
		wr <= w;
		do begin
			@(posedge mclk_in);
			n++;
		end while (wq !== 1'b0 && n < 50);
		if (n >= 50) chk_byte("waitrequest", 8'h00, 8'h01);
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd8(input string n, input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk_byte(n, e, q);
	endtask
	task automatic print_verdict();
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// =========================================
	// scenarios
	task automatic t_reset();
		chk_byte("oe", 8'h00, 8'(|poe));
		chk_byte("pd", 8'h00, 8'(|ppd));
		chk_byte("pu", 8'h01, 8'(ppu == 39'h0001000000));
		rd8("dirE", 8'h44, 8'h00);
		rd8("unmapped", 8'h5C, 8'h00);
	endtask
	task automatic t_readback();
		xe[38:35] <= 4'hF;
		xv[38:31] <= 8'h5A;
		wr8(8'h40, 8'h3C);
		wr8(8'h44, 8'h0F);
		tick(4);
		chk_byte("oeE", 8'h0F, poe[38:31]);
		chk_byte("outE", 8'h0C, pout[38:31] & poe[38:31]);
		rd8("dataE", 8'h40, 8'h5C);
		wr8(8'h48, 8'hFF);
		tick(2);
		chk_byte("puE", 8'hF0, ppu[38:31]);
		wr8(8'h44, 8'hFF);
		rd8("dataE2", 8'h40, 8'h3C);
	endtask
	task automatic t_porta();
		wr8(8'h04, 8'hFF);
		wr8(8'h00, 8'hFF);
		tick(2);
		chk_byte("oeA", 8'hFE, poe[7:0]);
		k1e <= 8'hF0;
		k1r <= 8'hF0;
		tick(3);
		chk_byte("oeAkbi", 8'h0E, poe[7:0]);
		wr8(8'h08, 8'hFF);
		wr8(8'h04, 8'h00);
		tick(2);
		chk_byte("pdA", 8'hF0, ppd[7:0]);
		chk_byte("puA", 8'h0F, ppu[7:0]);
		tick(3);
		chk_byte("lvlA", 8'h0F, plv[7:0]);
		k1e <= 8'h00;
	endtask
	task automatic t_periph();
		xe[14:9] <= 6'h3F;
		xv[14:9] <= 6'h01;
		xe[30:26] <= 5'h1F;
		xv[30:26] <= 5'h00;
		sci <= 1'b1;
		tx <= 1'b1;
		{t1o, t1e, t1v, t0o} <= 4'hF;
		spi <= 1'b1;
		spoe <= 4'hA;
		spdo <= 4'h8;
		k2e <= 4'hF;
		wr8(8'h24, 8'hFF);
		wr8(8'h10, 8'h00);
		wr8(8'h14, 8'h01);
		tick(4);
		chk_byte("oeB", 8'h81, poe[15:8]);
		chk_byte("outB", 8'h81, pout[15:8] & poe[15:8]);
		chk_byte("rx", 8'h01, rx);
		chk_byte("oeC", 8'hA0, poe[23:16]);
		chk_byte("outC", 8'h80, pout[23:16] & poe[23:16]);
		chk_byte("oeD6", 8'h01, poe[30]);
		rd8("dataB", 8'h10, 8'h82);
		{sci, tx, t1o, t1e, t1v, t0o, spi} <= 7'h00;
		k2e <= 4'h0;
	endtask
	task automatic t_portd();
		rdrv <= 1'b1;
		bk <= 1'b1;
		tick(4);
		chk_byte("oeD0", 8'h01, poe[24]);
		chk_byte("outD0", 8'h01, pout[24]);
		chk_byte("oeD1", 8'h01, poe[25]);
		chk_byte("outD1", 8'h00, pout[25]);
		rd8("dataD", 8'h30, 8'h01);
		wr8(8'h50, 8'h02);
		wr8(8'h30, 8'h02);
		wr8(8'h34, 8'h03);
		tick(4);
		chk_byte("oeD", 8'h03, poe[30:24]);
		chk_byte("puD0", 8'h00, ppu[24]);
		rd8("dataD2", 8'h30, 8'h00);
		rd8("ctrl", 8'h50, 8'h02);
		rdrv <= 1'b0;
		bk <= 1'b0;
	endtask
	task automatic t_stop();
		wr8(8'h40, 8'hA5);
		wr8(8'h44, 8'hFF);
		s2 <= 1'b1;
		tick(1);
		s2 <= 1'b0;
		tick(3);
		chk_byte("hold", 8'h01, hold);
		chk_byte("oeEheld", 8'hFF, poe[38:31]);
		chk_byte("outEheld", 8'hA5, pout[38:31]);
		rd8("dirEcleared", 8'h44, 8'h00);
		wr8(8'h40, 8'hA5);
		wr8(8'h44, 8'hFF);
		wr8(8'h50, 8'h01);
		tick(3);
		chk_byte("hold0", 8'h00, hold);
		chk_byte("outE", 8'hA5, pout[38:31]);
		s1 <= 1'b1;
		tick(1);
		s1 <= 1'b0;
		tick(3);
		chk_byte("oeStop1", 8'h00, 8'(|poe));
		chk_byte("puStop1", 8'h01, 8'(ppu == 39'h0001000000));
		rd8("dirEstop1", 8'h44, 8'h00);
		rd8("ctrlStop1", 8'h50, 8'h00);
	endtask
	// =========================================
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end
	initial begin
		// watchdog: the sequence needs well under 1000 cycles
		#200000;
		errors++;
		print_verdict();
	end
	initial begin
		{nrst_in, rd, wr, sci, tx, t1o, t1e, t1v, t0o, spi, rdrv, s1, s2, bk} = '0;
		{adr, k1e, k1r, k2e, spoe, spdo, wd} = '0;
		xv = '0;
		xe = '0;
		errors = 0;
		n_checks = 0;
		tick(16);
		nrst_in <= 1'b1;
		tick(3);
		t_reset();
		t_readback();
		t_porta();
		t_periph();
		t_portd();
		t_stop();
		print_verdict();
	end
endmodule
`default_nettype wire

/* testbench/fpio_pad_model.sv */
// pad model: outside world as seen by the port pins
`timescale 1ns/1ps
`default_nettype none
module fpio_pad_model (
	input  wire logic                    mclk_in,   // system clock
	input  wire fpio_pkg::fpio_pins_type drv_in,    // block drive value
	input  wire fpio_pkg::fpio_pins_type oe_in,     // block drive enable
	input  wire fpio_pkg::fpio_pins_type pu_in,     // pullup on
	input  wire fpio_pkg::fpio_pins_type pd_in,     // pulldown on
	input  wire fpio_pkg::fpio_pins_type ext_in,    // outside value
	input  wire fpio_pkg::fpio_pins_type ext_en_in, // outside drives
	output fpio_pkg::fpio_pins_type      pad_out    // resolved level
);
	import fpio_pkg::*;
	fpio_pins_type flt_q = '0;
	// =========================================
	// undriven pads wander, so a stale level is never read back
	always @(posedge mclk_in) begin
		flt_q <= ~flt_q;
	end
	assign pad_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in) | (~oe_in & ~ext_en_in & pu_in)
		| (~oe_in & ~ext_en_in & ~pu_in & ~pd_in & flt_q);
endmodule
`default_nettype wire
